/* verilog/adc_port_cfg.svh */
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH
// Conversion word and sampling interval layout
`define WORD_BITS        20
`define SLOT_COUNT       16
`define SLOT_PULSES      64
// Master clock pulses per self-clocked serial bit
`define BIT_PULSES       4
// Length of the data-ready overrun pulse, in master clock cycles
`define RDY_PULSE_CYCLES 3'h4
// Positions of the synchronised pins
`define IN_MCLK          0
`define IN_CS            1
`define IN_SCLK          2
`define IN_MODE          3
`define IN_COUNT         4
// Synchroniser reset: chip select idles high, the rest low
`define SYNC_RESET       4'h2
`endif

/* verilog/adc_port_pkg.sv */
package adc_port_pkg;
  // Transmission mode picked by the mode pin
  typedef enum logic [0:0] {
    external_clock_mode = 1'h0,
    self_clocked_mode   = 1'h1
  } mode_t;
  // Data-ready state: word waiting, no word, overrun pulse
  typedef enum logic [1:0] {
    rdy_word  = 2'h0,
    rdy_empty = 2'h1,
    rdy_pulse = 2'h2
  } rdy_t;
endpackage

/* verilog/adc_serial_output_port.sv */
`timescale 1ns/1ps
`include "adc_port_cfg.svh"
// Function
// R1 - Mode pin high selects self-clocked mode
// R2 - Interval is 16 slots of 64 pulses
// R3 - Poll chip select at digital slot start
// R4 - Self-clocked data only in digital slots
// R5 - Data-ready high after LSB until new word
// R6 - Chip select high: finish bit, then float
// R7 - Resume with next bit next digital slot
// R8 - Overrun: ready high four cycles, then load
// R9 - Self-clocked data changes on falling clock
// R10 - Chip select fall drives MSB at once
// R11 - External falling clock advances one bit
// R12 - External: after LSB float ready, data
// R13 - External busy transfer drops new word
// R14 - External chip select high floats data
// R15 - External resume repeats interrupted bit
// R16 - External overrun with select high: pulse
// R17 - Host should derive master clock itself
// R18 - Send the whole 20-bit word
module adc_serial_output_port
  import adc_port_pkg::*;
#(
  parameter int WORD_BITS   = `WORD_BITS,
  parameter int SLOT_COUNT  = `SLOT_COUNT,
  parameter int SLOT_PULSES = `SLOT_PULSES,
  parameter int BIT_PULSES  = `BIT_PULSES
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic                 master_clock_in,
  input  wire logic                 mode_pin,
  input  wire logic                 chip_select_n,
  input  wire logic                 serial_clock_in,
  input  wire logic [WORD_BITS-1:0] word_in,
  input  wire logic                 word_valid,
  output logic                      serial_data_out,
  output logic                      serial_data_oe_n,
  output logic                      serial_clock_out,
  output logic                      serial_clock_oe_n,
  output logic                      data_ready_n,
  output logic                      data_ready_oe_n
);

  localparam int PCNT_W = $clog2(SLOT_COUNT * SLOT_PULSES);
  localparam int SLOT_W = $clog2(SLOT_PULSES);
  localparam int PH_W   = $clog2(BIT_PULSES);
  localparam int IDX_W  = $clog2(WORD_BITS);
  localparam logic [IDX_W-1:0] MSB_IDX = IDX_W'(WORD_BITS - 1);
  localparam logic [PH_W-1:0]  PH_HALF = PH_W'(BIT_PULSES / 2);

  // Pin synchronisers; stage one feeds stage two only
  logic [`IN_COUNT-1:0] sync1;
  logic [`IN_COUNT-1:0] sync2;
  logic [`IN_COUNT-1:0] sync3;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= `SYNC_RESET;
      sync2 <= `SYNC_RESET;
      sync3 <= `SYNC_RESET;
    end else begin
      sync1 <= {mode_pin, serial_clock_in, chip_select_n, master_clock_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Edge detection on the synchronised copies
  mode_t mode;
  logic  mclk_rise;
  logic  cs_n_s;
  logic  cs_fall;
  logic  sclk_fall;

  assign mode      = sync2[`IN_MODE] ? self_clocked_mode : external_clock_mode; // R1
  assign mclk_rise = sync2[`IN_MCLK] && !sync3[`IN_MCLK];
  assign cs_n_s    = sync2[`IN_CS];
  assign cs_fall   = !sync2[`IN_CS] && sync3[`IN_CS];
  assign sclk_fall = !sync2[`IN_SCLK] && sync3[`IN_SCLK];

  // Port state
  logic [PCNT_W-1:0]    pulse_cnt;
  logic [PCNT_W-1:0]    next_pulse_cnt;
  rdy_t                 rdy_state;
  rdy_t                 next_rdy_state;
  logic [2:0]           pulse_left;
  logic [2:0]           next_pulse_left;
  logic [WORD_BITS-1:0] word_reg;
  logic [WORD_BITS-1:0] next_word_reg;
  logic [WORD_BITS-1:0] pend_word;
  logic [WORD_BITS-1:0] next_pend_word;
  logic [IDX_W-1:0]     bit_idx;
  logic [IDX_W-1:0]     next_bit_idx;
  logic                 sent;
  logic                 next_sent;
  logic                 slot_en;
  logic                 next_slot_en;
  logic                 bit_on;
  logic                 next_bit_on;
  logic                 sclk;
  logic                 next_sclk;
  logic                 data_bit;
  logic                 next_data_bit;
  logic                 ext_on;
  logic                 next_ext_on;
  logic                 rdy_oe_n;
  logic                 next_rdy_oe_n;
  logic                 load;
  logic [WORD_BITS-1:0] load_val;

  // Slot position of the master pulse now arriving
  logic digital;
  logic slot_start;
  logic phase_zero;
  logic phase_half;

  assign digital    = pulse_cnt[PCNT_W-1];                        // R2
  assign slot_start = (pulse_cnt[SLOT_W-1:0] == '0);              // R2
  assign phase_zero = (pulse_cnt[PH_W-1:0] == '0);
  assign phase_half = (pulse_cnt[PH_W-1:0] == PH_HALF);

  // Next-state logic for both modes and the word hand-off
  always_comb begin
    next_pulse_cnt  = pulse_cnt;
    next_rdy_state  = rdy_state;
    next_pulse_left = pulse_left;
    next_word_reg   = word_reg;
    next_pend_word  = pend_word;
    next_bit_idx    = bit_idx;
    next_sent       = sent;
    next_slot_en    = slot_en;
    next_bit_on     = bit_on;
    next_sclk       = sclk;
    next_data_bit   = data_bit;
    next_ext_on     = ext_on;
    next_rdy_oe_n   = rdy_oe_n;
    load            = 1'b0;
    load_val        = word_reg;
    if (mclk_rise) begin
      next_pulse_cnt = pulse_cnt + 1'b1;                          // R2
    end
    // Self-clocked: bits are framed by master pulses
    if (mode == self_clocked_mode) begin
      if (mclk_rise && rdy_state != rdy_pulse) begin
        if (phase_zero) begin
          if (bit_on) begin
            next_bit_on = 1'b0;
            if (bit_idx == '0) begin
              next_sent      = 1'b1;                              // R18
              next_rdy_state = rdy_empty;                         // R5
            end else begin
              next_bit_idx = bit_idx - 1'b1;                      // R7
            end
          end
          // Poll at slot start, stop at bit end if select rose
          next_slot_en = digital && !cs_n_s && (slot_start || slot_en); // R3 R4 R6
          if (next_slot_en && !next_sent) begin
            next_bit_on = 1'b1;
            next_sclk   = 1'b0;                                   // R9
            next_data_bit = word_reg[next_bit_idx];               // R3 R9
          end else begin
            next_sclk = 1'b1;
          end
        end else if (phase_half && bit_on) begin
          next_sclk = 1'b1;
        end
      end
    end else begin
      // External clock: host edges step the word
      if (cs_fall && !sent) begin
        next_ext_on   = 1'b1;                                     // R10
        next_data_bit = word_reg[bit_idx];                        // R10 R15
      end else if (sclk_fall && ext_on && !cs_n_s && !sent) begin
        if (bit_idx == '0) begin
          next_sent      = 1'b1;                                  // R18
          next_ext_on    = 1'b0;
          next_rdy_oe_n  = 1'b1;                                  // R12
          next_rdy_state = rdy_empty;
        end else begin
          next_bit_idx  = bit_idx - 1'b1;                         // R11
          next_data_bit = word_reg[bit_idx - 1'b1];               // R11
        end
      end
    end
    // New words: load, drop, or overrun pulse first
    unique case (rdy_state)
      rdy_pulse: begin
        if (word_valid) begin
          next_pend_word = word_in;
        end
        if (mclk_rise) begin
          if (pulse_left == 3'h1) begin
            load     = 1'b1;                                      // R8 R16
            load_val = word_valid ? word_in : pend_word;
          end else begin
            next_pulse_left = pulse_left - 1'b1;
          end
        end
      end
      rdy_word, rdy_empty: begin
        if (word_valid) begin
          if (mode == external_clock_mode && !cs_n_s && ext_on && !next_sent) begin
            next_pend_word = pend_word;                           // R13
          end else if (next_sent) begin
            load     = 1'b1;
            load_val = word_in;
          end else begin
            next_pend_word  = word_in;
            next_rdy_state  = rdy_pulse;                          // R8 R16
            next_pulse_left = `RDY_PULSE_CYCLES;
          end
        end
      end
      default: begin
        next_rdy_state = rdy_empty;
      end
    endcase
    // Loading restarts the word at its MSB
    if (load) begin
      next_word_reg  = load_val;
      next_bit_idx   = MSB_IDX;                                   // R18
      next_sent      = 1'b0;
      next_rdy_state = rdy_word;
      next_bit_on    = 1'b0;
      next_slot_en   = 1'b0;
      next_sclk      = 1'b1;
      next_ext_on    = 1'b0;
      next_rdy_oe_n  = 1'b0;
      next_data_bit  = load_val[WORD_BITS-1];
    end
  end

  // State registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pulse_cnt  <= '0;
      rdy_state  <= rdy_empty;
      pulse_left <= 3'h0;
      word_reg   <= '0;
      pend_word  <= '0;
      bit_idx    <= MSB_IDX;
      sent       <= 1'b1;
      slot_en    <= 1'b0;
      bit_on     <= 1'b0;
      sclk       <= 1'b1;
      data_bit   <= 1'b0;
      ext_on     <= 1'b0;
      rdy_oe_n   <= 1'b0;
    end else begin
      pulse_cnt  <= next_pulse_cnt;
      rdy_state  <= next_rdy_state;
      pulse_left <= next_pulse_left;
      word_reg   <= next_word_reg;
      pend_word  <= next_pend_word;
      bit_idx    <= next_bit_idx;
      sent       <= next_sent;
      slot_en    <= next_slot_en;
      bit_on     <= next_bit_on;
      sclk       <= next_sclk;
      data_bit   <= next_data_bit;
      ext_on     <= next_ext_on;
      rdy_oe_n   <= next_rdy_oe_n;
    end
  end

  // Pin drivers; enables are decoded from registered state
  assign serial_data_out   = data_bit;
  assign serial_clock_out  = sclk;
  assign data_ready_n      = (rdy_state != rdy_word);             // R5
  assign data_ready_oe_n   = rdy_oe_n;                            // R12
  assign serial_clock_oe_n = !(mode == self_clocked_mode && bit_on); // R1 R6
  // Select high floats the external data line within the sync delay
  assign serial_data_oe_n  = (mode == self_clocked_mode) ? !bit_on
                           : !(ext_on && !cs_n_s && !sent);       // R14 R12

  a_ext_no_clock: assert property (@(posedge clk_sys) disable iff (!reset_n) // R1
    (!mode_pin) [*3] |-> serial_clock_oe_n)
    else $error("serial clock driven in external mode");

  a_slot_data_only: assert property (@(posedge clk_sys) disable iff (!reset_n) // R4
    mode == self_clocked_mode && bit_on |-> digital || pulse_cnt == '0)
    else $error("self-clocked data outside digital slots");

  a_poll_starts_bit: assert property (@(posedge clk_sys) disable iff (!reset_n) // R3
    mode == self_clocked_mode && mclk_rise && slot_start && digital && !cs_n_s
    && !sent && !bit_on && rdy_state != rdy_pulse
    |=> bit_on && !serial_clock_out && serial_data_out == word_reg[bit_idx])
    else $error("no bit started at digital slot poll");

  a_cs_finish_bit: assert property (@(posedge clk_sys) disable iff (!reset_n) // R6
    mode == self_clocked_mode && bit_on && cs_n_s && mclk_rise && !phase_zero
    && rdy_state != rdy_pulse && !word_valid |=> bit_on)
    else $error("self-clocked bit cut short");

  a_data_on_fall: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
    mode == self_clocked_mode && bit_on && $changed(serial_data_out) |-> !serial_clock_out)
    else $error("data changed while serial clock high");

  a_self_ready_high: assert property (@(posedge clk_sys) disable iff (!reset_n) // R5
    mode == self_clocked_mode && $rose(sent) |-> data_ready_n && !data_ready_oe_n)
    else $error("data ready not high after last bit");

  a_pulse_start: assert property (@(posedge clk_sys) disable iff (!reset_n) // R8
    $rose(rdy_state == rdy_pulse) |-> data_ready_n && pulse_left == `RDY_PULSE_CYCLES)
    else $error("overrun pulse started with wrong length");

  a_pulse_load: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
    rdy_state == rdy_pulse && mclk_rise && pulse_left == 3'h1
    |=> !data_ready_n && bit_idx == MSB_IDX && !sent)
    else $error("new word not loaded after overrun pulse");

  a_ext_cs_float: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14
    (!mode_pin && chip_select_n) [*3] |-> serial_data_oe_n)
    else $error("data driven with chip select high");

  a_ext_resume_bit: assert property (@(posedge clk_sys) disable iff (!reset_n) // R15
    mode == external_clock_mode && cs_fall && !sent && !word_valid
    && rdy_state != rdy_pulse
    |=> !serial_data_oe_n && serial_data_out == word_reg[$past(bit_idx)])
    else $error("external transfer did not resume on same bit");

  a_ext_lsb_float: assert property (@(posedge clk_sys) disable iff (!reset_n) // R12
    mode == external_clock_mode && $rose(sent) |-> serial_data_oe_n && data_ready_oe_n)
    else $error("outputs still driven after last bit");

  a_ext_drop_word: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
    mode == external_clock_mode && word_valid && !cs_n_s && ext_on && !sent
    && rdy_state != rdy_pulse && !(sclk_fall && bit_idx == '0) |=> $stable(word_reg))
    else $error("busy external transfer took a new word");

endmodule // adc_serial_output_port

/* tb/serial_host.sv */
`timescale 1ns/1ps
// Host side: shift register in self-clocked mode, serial port master otherwise
module serial_host (
  input  wire logic clk_sys,
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe_n,
  input  wire logic serial_clock_out,
  input  wire logic serial_clock_oe_n,
  output logic      serial_clock_in
);
  logic        last_data  = 1'h0;
  logic        prev_clock = 1'h1;
  logic        data_line;
  logic        clock_line;
  logic [19:0] rx_word    = 20'h00000;
  int          rx_bits    = 0;
  // Released data never shows a stale copy; the clock line has a pull-up
  assign data_line  = serial_data_oe_n ? ~last_data : serial_data_out;
  assign clock_line = serial_clock_oe_n ? 1'h1 : serial_clock_out;
  initial serial_clock_in = 1'h1;
  // Shift in on the rising edge of the device clock
  always @(posedge clk_sys) begin
    last_data  <= data_line;
    prev_clock <= clock_line;
    if (clock_line && !prev_clock) begin
      rx_word = {rx_word[18:0], data_line};
      rx_bits++;
    end
  end
  task automatic clear();
    rx_word = 20'h00000;
    rx_bits = 0;
  endtask
  // Host clock stands high between frames; sample just before each fall
  task automatic clock_bits(input int n);
    // Step off the sampling edge so the clock never moves on it
    #1;
    for (int i = 0; i < n; i++) begin
      #80 rx_word = {rx_word[18:0], data_line};
      rx_bits++;
      serial_clock_in = 1'h0;
      #80 serial_clock_in = 1'h1;
    end
  endtask
endmodule // serial_host

/* tb/adc_serial_output_port_tb.sv */
`timescale 1ns/1ps
module adc_serial_output_port_tb;
  import adc_port_pkg::*;
  localparam int WB = 20;
  logic          clk_sys = 1'h0;
  logic          reset_n = 1'h0;
  logic          master_clock_in = 1'h0;
  logic          mode_pin = 1'h1;
  logic          chip_select_n = 1'h1;
  logic          word_valid = 1'h0;
  logic [WB-1:0] word_in = 20'h00000;
  logic          serial_clock_in;
  logic          serial_data_out;
  logic          serial_data_oe_n;
  logic          serial_clock_out;
  logic          serial_clock_oe_n;
  logic          data_ready_n;
  logic          data_ready_oe_n;
  int            num_errors = 0;
  int            checks = 0;
  int            seed = 78;
  int            cycles = 0;
  int            mcnt = 0;
  int            exp_q[$];
  // Short slots keep a sampling interval near 2048 system cycles
  adc_serial_output_port #(.SLOT_PULSES(16)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .master_clock_in(master_clock_in),
    .mode_pin(mode_pin), .chip_select_n(chip_select_n), .serial_clock_in(serial_clock_in),
    .word_in(word_in), .word_valid(word_valid), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .serial_clock_out(serial_clock_out),
    .serial_clock_oe_n(serial_clock_oe_n), .data_ready_n(data_ready_n),
    .data_ready_oe_n(data_ready_oe_n));
  serial_host host (
    .clk_sys(clk_sys), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .serial_clock_out(serial_clock_out),
    .serial_clock_oe_n(serial_clock_oe_n), .serial_clock_in(serial_clock_in));
  always #2.5 clk_sys = ~clk_sys;
  // Master clock is one eighth of the system clock, locked to it; also the hang limit
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles % 4 == 0) master_clock_in <= #1 ~master_clock_in;
    if (cycles > 60000) begin
      num_errors++;
      complete_run();
    end
  end
  // Count master pulses while the ready line is high
  always @(posedge master_clock_in) if (data_ready_n === 1'h1) mcnt++;
  task automatic check(input logic [WB-1:0] seen, input logic [WB-1:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Model: one held word; a busy external transfer drops the new one
  task automatic load(input bit busy);
    logic [WB-1:0] w;
    w = WB'($random(seed));
    @(posedge clk_sys);
    #1 word_in = w;
    word_valid = 1'h1;
    @(posedge clk_sys);
    #1 word_valid = 1'h0;
    if (!busy) begin
      if (exp_q.size() > 0) exp_q.pop_back();
      exp_q.push_back(int'(w));
    end
  endtask
  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (host.rx_bits < n && k < 20000) begin
      @(posedge clk_sys);
      k++;
    end
  endtask
  task automatic run_mode(input logic m);
    int k;
    @(posedge clk_sys);
    #1 mode_pin = m;
    repeat (8) @(posedge clk_sys);
    load(1'b0);
    repeat (2) @(posedge clk_sys);
    check(WB'(data_ready_n), 20'h00000, "word waiting");
    // Second word while select is high: ready pulses, then the new word loads
    @(posedge master_clock_in);
    repeat (4) @(posedge clk_sys);
    mcnt = 0;
    load(1'b0);
    k = 0;
    while (data_ready_n !== 1'h0 && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    check(WB'(mcnt), 20'h00004, "overrun pulse length");
    host.clear();
    #1 chip_select_n = 1'h0;
    if (m) begin
      wait_bits(7);
      #1 chip_select_n = 1'h1;
      repeat (2100) @(posedge clk_sys);
      check(WB'(host.rx_bits), 20'h00007, "bits after select high");
      check(WB'(serial_clock_oe_n), 20'h00001, "clock released");
      #1 chip_select_n = 1'h0;
      wait_bits(WB);
      repeat (20) @(posedge clk_sys);
      check(WB'(data_ready_n), 20'h00001, "ready after last bit");
    end else begin
      repeat (8) @(posedge clk_sys);
      check(WB'(host.data_line), WB'(exp_q[0] >> (WB - 1)), "first bit");
      host.clock_bits(5);
      load(1'b1);
      @(posedge clk_sys);
      #1 chip_select_n = 1'h1;
      repeat (4) @(posedge clk_sys);
      check(WB'(serial_data_oe_n), 20'h00001, "data released");
      #1 chip_select_n = 1'h0;
      repeat (8) @(posedge clk_sys);
      host.clock_bits(WB - 5);
      repeat (8) @(posedge clk_sys);
      check(WB'({serial_data_oe_n, data_ready_oe_n}), 20'h00003, "released after lsb");
    end
    check(host.rx_word, WB'(exp_q[0]), "received word");
    #1 chip_select_n = 1'h1;
  endtask
  // Main sequence: reset, then both transmission modes
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 reset_n = 1'h1;
    check(WB'(data_ready_n), 20'h00001, "ready after reset");
    run_mode(1'h1);
    run_mode(1'h0);
    complete_run();
  end
endmodule // adc_serial_output_port_tb
